// ### bench/chan_cal_regs_assertions.sv
// Purpose: port checks for chan_cal_regs
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the bank
`timescale 1ns/1ns
module chan_cal_regs_assertions
(
   input wire        clk_i,
   input wire        rst_i,
   input wire        s_axi_awvalid_i,
   input wire        s_axi_awready_o,
   input wire        s_axi_bvalid_o,
   input wire        s_axi_bready_i,
   input wire [1:0]  s_axi_bresp_o,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire        s_axi_rvalid_o,
   input wire        s_axi_rready_i,
   input wire [31:0] s_axi_rdata_o,
   input wire        conv_start_i,
   input wire [9:0]  chan_phase_delay_o,
   input wire [23:0] offset_cal_o,
   input wire [23:0] gain_cal_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // applied values come out of reset at unity gain, no offset
   a_gain_unity_reset: assert property ($fell(rst_i) |-> gain_cal_o == 24'h800000)
      else $error("gain not unity after reset");
   a_offset_zero_reset: assert property ($fell(rst_i) |-> offset_cal_o == 24'h0 && chan_phase_delay_o == 10'h0)
      else $error("offset or phase not zero after reset");
   // settings must not leak into a running conversion
   a_phase_hold: assert property (!conv_start_i |=> $stable(chan_phase_delay_o))
      else $error("phase changed without conversion start");
   a_cal_hold: assert property (!conv_start_i |=> $stable(offset_cal_o) && $stable(gain_cal_o))
      else $error("calibration changed without conversion start");
   // bus answers stand until taken
   a_bresp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped early");
   a_rdata_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped early");
   a_read_answer: assert property (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o |=> s_axi_arready_o && s_axi_rvalid_o)
      else $error("read not answered next cycle");
   a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[1:3] s_axi_bvalid_o)
      else $error("write response missing");
   a_awready_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o)
      else $error("address ready held two cycles");
endmodule // chan_cal_regs_assertions

bind chan_cal_regs chan_cal_regs_assertions u_chan_cal_regs_assertions
(
   .clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
   .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .conv_start_i,
   .chan_phase_delay_o, .offset_cal_o, .gain_cal_o
);

// ### bench/tb.sv
// Purpose: self-checking bench for chan_cal_regs
// Assumes: byte address is four times the word index
// Notes:   rows write a value and expect the masked read back
`timescale 1ns/1ns
`include "chan_cal_consts.vh"
module tb;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
   logic        clk_i = 1'h0, rst_i = 1'h1, conv_start_i = 1'h0;
   logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
   logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
   logic [9:0]  s_axi_awaddr_i = 10'h0, s_axi_araddr_i = 10'h0;
   logic [31:0] s_axi_wdata_i = 32'h0;
   logic [3:0]  s_axi_wstrb_i = 4'hF;
   wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o, chan_input_select_o, chan5_input_select_o;
   wire  [31:0] s_axi_rdata_o;
   wire  [9:0]  chan_phase_delay_o;
   wire         chan_filter_bypass_o;
   wire  [23:0] offset_cal_o, gain_cal_o;
   int          n_mismatch = 0, samples_checked = 0, i;
   logic [1:0]  rsp;
   logic [15:0] rd;
   logic [7:0]  t_idx [7] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h1C};
   logic [15:0] t_wr  [7] = '{16'hFFFF, 16'h8001, 16'hFFFF, 16'h1234, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   logic [15:0] t_exp [7] = '{16'hFFC7, 16'h8001, 16'hFF00, 16'h1234, 16'hFF00, 16'hFFC7, 16'hFF00};
   logic [15:0] t_rst [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};

   chan_cal_regs u_chan_cal_regs
   (
      .clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
      .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
      .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
      .conv_start_i, .chan_phase_delay_o, .chan_filter_bypass_o, .chan_input_select_o, .offset_cal_o,
      .gain_cal_o, .chan5_input_select_o
   );

   // one write; bready comes late so the response must stand
   task automatic axw(input [7:0] idx, input [15:0] d, output [1:0] r);
      @(posedge clk_i);
      s_axi_awaddr_i <= {idx, 2'h0};
      s_axi_wdata_i <= {16'h0000, d};
      s_axi_awvalid_i <= 1'h1;
      s_axi_wvalid_i <= 1'h1;
      r = 2'h1;
      forever
      begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
         if (s_axi_bvalid_o && s_axi_bready_i)
         begin
            r = s_axi_bresp_o;
            s_axi_bready_i <= 1'h0;
            break;
         end
         if (s_axi_bvalid_o) s_axi_bready_i <= 1'h1;
      end
   endtask

   // one read, same late-ready habit
   task automatic axr(input [7:0] idx, output [15:0] d, output [1:0] r);
      @(posedge clk_i);
      s_axi_araddr_i <= {idx, 2'h0};
      s_axi_arvalid_i <= 1'h1;
      r = 2'h1;
      d = 16'h0;
      forever
      begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
         if (s_axi_rvalid_o && s_axi_rready_i)
         begin
            r = s_axi_rresp_o;
            d = s_axi_rdata_o[15:0];
            s_axi_rready_i <= 1'h0;
            break;
         end
         if (s_axi_rvalid_o) s_axi_rready_i <= 1'h1;
      end
   endtask

   task automatic chkreg(input [7:0] idx, input [15:0] e);
      axr(idx, rd, rsp);
      `CHK(rsp, `RESP_OKAY)
      `CHK(rd, e)
   endtask

   // single conversion strobe, outputs settle after its edge
   task automatic conv;
      @(posedge clk_i);
      conv_start_i <= 1'h1;
      @(posedge clk_i);
      conv_start_i <= 1'h0;
      #1;
   endtask

   task automatic conclude;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always #25 clk_i = ~clk_i;

   // watchdog, far beyond the few hundred cycles needed
   initial
   begin
      #1000000;
      n_mismatch++;
      conclude;
   end

   // main sequence: rows, applied values, codes, errors, reset
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'h0;
      for (i = 0; i < 7; i++)
      begin
         axw(t_idx[i], t_wr[i], rsp);
         `CHK(rsp, `RESP_OKAY)
         chkreg(t_idx[i], t_exp[i]);
      end
      `CHK(gain_cal_o, 24'h800000)
      `CHK(chan5_input_select_o, `MUX_NEG_TEST)
      conv;
      `CHK({chan_phase_delay_o, chan_filter_bypass_o}, 11'h7FF)
      `CHK(offset_cal_o, 24'h8001FF)
      `CHK(gain_cal_o, 24'h1234FF)
      // every select code, most negative phase, bypass bit clear
      for (i = 0; i < 4; i++)
      begin
         axw(8'h1D, {10'h200, 4'h0, i[1:0]}, rsp);
         conv;
         `CHK({chan_phase_delay_o, chan_filter_bypass_o, chan_input_select_o}, {10'h200, 1'h0, i[1:0]})
      end
      // global setting bypasses even with the channel bit clear
      axw(8'h30, 16'h0001, rsp);
      conv;
      `CHK(chan_filter_bypass_o, 1'h1)
      chkreg(8'h31, 16'h8007);
      // low byte lane only
      s_axi_wstrb_i <= 4'h1;
      axw(8'h1E, 16'hABCD, rsp);
      s_axi_wstrb_i <= 4'hF;
      chkreg(8'h1E, 16'h80CD);
      axw(8'h3F, 16'hFFFF, rsp);
      `CHK(rsp, `RESP_SLVERR)
      axr(8'h3F, rd, rsp);
      `CHK(rsp, `RESP_SLVERR)
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      for (i = 0; i < 7; i++)
         chkreg(t_idx[i], t_rst[i]);
      `CHK(gain_cal_o, 24'h800000)
      conclude;
   end
endmodule // tb

// ### pkg/chan_cal_consts.vh
// Purpose: register map constants for the channel calibration register bank
// Assumes: word-indexed map, byte address is four times the index
// Notes:   definitions only
`ifndef CHAN_CAL_CONSTS_VH
`define CHAN_CAL_CONSTS_VH

// register indices
`define IDX_CHAN3_GAIN_LOW   8'h1C
`define IDX_CHAN4_CONFIG     8'h1D
`define IDX_CHAN4_OFS_HIGH   8'h1E
`define IDX_CHAN4_OFS_LOW    8'h1F
`define IDX_CHAN4_GAIN_HIGH  8'h20
`define IDX_CHAN4_GAIN_LOW   8'h21
`define IDX_CHAN5_CONFIG     8'h22
`define IDX_GLOBAL_CTRL      8'h30
`define IDX_APPLIED_STATUS   8'h31

// reset values
`define RST_CONFIG           16'h0000
`define RST_OFS              16'h0000
`define RST_GAIN_HIGH        16'h8000
`define RST_GAIN_LOW         16'h0000

// field masks
`define MASK_CONFIG          16'hFFC7
`define MASK_LOW_BYTE_RES    16'hFF00
`define MASK_GLOBAL_CTRL     16'h0001

// config field positions
`define PHASE_MSB            15
`define PHASE_LSB            6
`define DCOFF_BIT            2
`define MUX_MSB              1
`define MUX_LSB              0

// input select codes
`define MUX_PINS             2'h0
`define MUX_SHORTED          2'h1
`define MUX_POS_TEST         2'h2
`define MUX_NEG_TEST         2'h3

// axi response codes
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ### rtl/chan_cal_regs.v
// Purpose: channel 4 configuration and calibration register bank on AXI4-Lite
// Assumes: one clock, synchronous active-high reset, conversion strobe from the filter
// Notes:   registers are 16 bits in the low half of each 32-bit word
//          write: awready and wready pulse one cycle after their valid is seen,
//          bvalid follows one cycle after both are held and stands until bready
//          read: arready, rvalid and data come together one cycle after arvalid
//          unmapped indices answer with an error response and change nothing
//          limitation: software must rewrite both halves of a 24-bit value before
//          the next conversion start, or the filter sees old and new halves mixed
//
// Behaviour
// - config bits 15:6 hold signed phase delay in modulator clock cycles
// - config bits 5:3 are read-only and always return zero
// - dc filter off bit 2 is ORed with global setting; 1 bypasses this channel
// - input select: 00 pins, 01 shorted, 10 positive test, 11 negative test
// - offset is 24-bit signed; high register supplies bits 23:8
// - offset low upper byte holds bits 7:0; lower byte reads zero
// - gain is 24-bit unsigned, 0.0 to just under 2.0; high holds 23:8
// - gain low upper byte holds bits 7:0; lower byte reads zero
// - previous channel gain low has the same layout, lower byte zero
// - gain high at 20h, resets to 8000h for unity gain
// - channel config at 1Dh, resets to zero
// - offset high at 1Eh, resets to zero
// - offset low at 1Fh, resets to zero
// - gain low at 21h, resets to zero
// - next channel config at 22h, resets to zero
`timescale 1ns/1ns
`include "chan_cal_consts.vh"

module chan_cal_regs
(
   input  wire        clk_i,
   input  wire        rst_i,
   // axi4-lite slave
   input  wire [9:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output reg         s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output reg         s_axi_wready_o,
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [9:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output reg         s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // conversion side
   input  wire        conv_start_i,
   output reg  [9:0]  chan_phase_delay_o,
   output reg         chan_filter_bypass_o,
   output reg  [1:0]  chan_input_select_o,
   output reg  [23:0] offset_cal_o,
   output reg  [23:0] gain_cal_o,
   output reg  [1:0]  chan5_input_select_o
);

   // register storage
   reg [15:0]  chan3_gain_low;
   reg [15:0]  chan4_config;
   reg [15:0]  chan4_offset_high;
   reg [15:0]  chan4_offset_low;
   reg [15:0]  chan4_gain_high;
   reg [15:0]  chan4_gain_low;
   reg [15:0]  chan5_config;
   reg [15:0]  global_ctrl;

   // write channel capture: address and data may arrive in either order
   reg         aw_held;
   reg         w_held;
   reg [7:0]   aw_idx;
   reg [31:0]  w_data;
   reg [3:0]   w_strb;
   wire        do_write;
   reg         wr_hit;
   reg [15:0]  wr_mask;
   wire [15:0] byte_en;
   wire        global_dc_filter_setting;

   assign do_write = aw_held && w_held && !s_axi_bvalid_o;
   assign byte_en  = {{8{w_strb[1]}}, {8{w_strb[0]}}};
   assign global_dc_filter_setting = global_ctrl[0];

   // address decode for writes; reserved bits masked out here
   always @*
   begin
      wr_hit  = 1'b1;
      wr_mask = 16'h0000;
      case (aw_idx)
         `IDX_CHAN3_GAIN_LOW:
            wr_mask = `MASK_LOW_BYTE_RES;
         `IDX_CHAN4_CONFIG:
            wr_mask = `MASK_CONFIG;
         `IDX_CHAN4_OFS_HIGH:
            wr_mask = 16'hFFFF;
         `IDX_CHAN4_OFS_LOW:
            wr_mask = `MASK_LOW_BYTE_RES;
         `IDX_CHAN4_GAIN_HIGH:
            wr_mask = 16'hFFFF;
         `IDX_CHAN4_GAIN_LOW:
            wr_mask = `MASK_LOW_BYTE_RES;
         `IDX_CHAN5_CONFIG:
            wr_mask = `MASK_CONFIG;
         `IDX_GLOBAL_CTRL:
            wr_mask = `MASK_GLOBAL_CTRL;
         `IDX_APPLIED_STATUS:
            wr_mask = 16'h0000;            // status is read-only, write is dropped
         default:
            wr_hit  = 1'b0;
      endcase
   end

   // write address capture; one address held until its write completes,
   // so a second write cannot overtake the first one's response
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         aw_held         <= 1'b0;
         aw_idx          <= 8'h00;
         s_axi_awready_o <= 1'b0;
      end
      else
      begin
         s_axi_awready_o <= 1'b0;
         if (s_axi_awvalid_i && !aw_held && !s_axi_awready_o)
         begin
            s_axi_awready_o <= 1'b1;
            aw_held         <= 1'b1;
            aw_idx          <= s_axi_awaddr_i[9:2];
         end
         else if (do_write)
            aw_held <= 1'b0;
      end
   end

   // write data capture; independent of the address so either may lead
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         w_held         <= 1'b0;
         w_data         <= 32'h00000000;
         w_strb         <= 4'h0;
         s_axi_wready_o <= 1'b0;
      end
      else
      begin
         s_axi_wready_o <= 1'b0;
         if (s_axi_wvalid_i && !w_held && !s_axi_wready_o)
         begin
            s_axi_wready_o <= 1'b1;
            w_held         <= 1'b1;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   // write response; stands until the master takes it
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // register update; only writable bits under a byte strobe change
   wire [15:0] wmask = wr_mask & byte_en;
   wire [15:0] wval  = w_data[15:0];

   // merged candidates for every register; the case below picks the one addressed
   reg [15:0]  next_chan3_gain_low;
   reg [15:0]  next_chan4_config;
   reg [15:0]  next_chan4_offset_high;
   reg [15:0]  next_chan4_offset_low;
   reg [15:0]  next_chan4_gain_high;
   reg [15:0]  next_chan4_gain_low;
   reg [15:0]  next_chan5_config;
   reg [15:0]  next_global_ctrl;

   always @*
   begin
      next_chan3_gain_low    = (chan3_gain_low & ~wmask) | (wval & wmask);
      next_chan4_config      = (chan4_config & ~wmask) | (wval & wmask);
      next_chan4_offset_high = (chan4_offset_high & ~wmask) | (wval & wmask);
      next_chan4_offset_low  = (chan4_offset_low & ~wmask) | (wval & wmask);
      next_chan4_gain_high   = (chan4_gain_high & ~wmask) | (wval & wmask);
      next_chan4_gain_low    = (chan4_gain_low & ~wmask) | (wval & wmask);
      next_chan5_config      = (chan5_config & ~wmask) | (wval & wmask);
      next_global_ctrl       = (global_ctrl & ~wmask) | (wval & wmask);
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chan3_gain_low    <= `RST_GAIN_LOW;
         chan4_config      <= `RST_CONFIG;
         chan4_offset_high <= `RST_OFS;
         chan4_offset_low  <= `RST_OFS;
         chan4_gain_high   <= `RST_GAIN_HIGH;
         chan4_gain_low    <= `RST_GAIN_LOW;
         chan5_config      <= `RST_CONFIG;
         global_ctrl       <= 16'h0000;
      end
      else if (do_write)
      begin
         case (aw_idx)
            `IDX_CHAN3_GAIN_LOW:
               chan3_gain_low    <= next_chan3_gain_low;
            `IDX_CHAN4_CONFIG:
               chan4_config      <= next_chan4_config;
            `IDX_CHAN4_OFS_HIGH:
               chan4_offset_high <= next_chan4_offset_high;
            `IDX_CHAN4_OFS_LOW:
               chan4_offset_low  <= next_chan4_offset_low;
            `IDX_CHAN4_GAIN_HIGH:
               chan4_gain_high   <= next_chan4_gain_high;
            `IDX_CHAN4_GAIN_LOW:
               chan4_gain_low    <= next_chan4_gain_low;
            `IDX_CHAN5_CONFIG:
               chan5_config      <= next_chan5_config;
            `IDX_GLOBAL_CTRL:
               global_ctrl       <= next_global_ctrl;
            default:
               global_ctrl       <= global_ctrl;  // unmapped or status: nothing changes
         endcase
      end
   end

   // read mux; reserved bits are masked or tied to zero here, except global control, whose storage never holds them
   reg [15:0] rd_val;
   reg        rd_hit;

   always @*
   begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      case (s_axi_araddr_i[9:2])
         `IDX_CHAN3_GAIN_LOW:
            rd_val = chan3_gain_low & `MASK_LOW_BYTE_RES;
         `IDX_CHAN4_CONFIG:
            rd_val = chan4_config & `MASK_CONFIG;
         `IDX_CHAN4_OFS_HIGH:
            rd_val = chan4_offset_high;
         `IDX_CHAN4_OFS_LOW:
            rd_val = chan4_offset_low & `MASK_LOW_BYTE_RES;
         `IDX_CHAN4_GAIN_HIGH:
            rd_val = chan4_gain_high;
         `IDX_CHAN4_GAIN_LOW:
            rd_val = chan4_gain_low & `MASK_LOW_BYTE_RES;
         `IDX_CHAN5_CONFIG:
            rd_val = chan5_config & `MASK_CONFIG;
         `IDX_GLOBAL_CTRL:
            rd_val = global_ctrl;
         `IDX_APPLIED_STATUS:
            rd_val = {chan_phase_delay_o, 3'h0, chan_filter_bypass_o, chan_input_select_o};
         default:
            rd_hit = 1'b0;
      endcase
   end

   // axi read handshake; data registered with the response
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready_o <= 1'b0;
         if (s_axi_arvalid_i && !s_axi_rvalid_o && !s_axi_arready_o)
         begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= {16'h0000, rd_val};
            s_axi_rresp_o   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_rvalid_o && s_axi_rready_i)
            s_axi_rvalid_o <= 1'b0;
      end
   end

   // bypass when this channel opts out or the global setting disables all
   wire        next_filter_bypass = chan4_config[`DCOFF_BIT] | global_dc_filter_setting;

   // next channel's select is not latched by conversion start: its own
   // conversion strobe lives outside this bank
   always @(posedge clk_i)
   begin
      if (rst_i)
         chan5_input_select_o <= `MUX_PINS;
      else
         chan5_input_select_o <= chan5_config[`MUX_MSB:`MUX_LSB];
   end

   // applied settings: loaded only at conversion start, so a half-written
   // 24-bit value never reaches the filter mid-conversion
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chan_phase_delay_o   <= 10'h000;
         chan_filter_bypass_o <= 1'b0;
         chan_input_select_o  <= `MUX_PINS;
         offset_cal_o         <= 24'h000000;
         gain_cal_o           <= {`RST_GAIN_HIGH, 8'h00};
      end
      else
      begin
         if (conv_start_i)
         begin
            chan_phase_delay_o   <= chan4_config[`PHASE_MSB:`PHASE_LSB];
            chan_filter_bypass_o <= next_filter_bypass;
            chan_input_select_o  <= chan4_config[`MUX_MSB:`MUX_LSB];
            offset_cal_o         <= {chan4_offset_high, chan4_offset_low[15:8]};
            gain_cal_o           <= {chan4_gain_high, chan4_gain_low[15:8]};
         end
      end
   end

endmodule // chan_cal_regs
